// file: rtl/pld_map.svh
/*
 * Register indices, byte addresses, field positions, reset values and
 * window timing for the lock-detect and analog-enable block.
 * Assumes a Wishbone slave with one 32-bit word per register index.
 */
`ifndef PLD_MAP_SVH
`define PLD_MAP_SVH

// ----------------------------------------------------------------
// register indices; byte address is four times the index
// ----------------------------------------------------------------
`define PLD_IDX_LDCFG 8'h07
`define PLD_IDX_ANAEN 8'h08
`define PLD_IDX_STAT 8'h10
`define PLD_IDX_CLR 8'h11
`define PLD_IDX_IEN 8'h12
`define PLD_IDX_PIN 8'h13
`define PLD_ADDR_W 8

// ----------------------------------------------------------------
// lock_detect_config fields
// ----------------------------------------------------------------
`define PLD_LD_CNT_LSB 0
`define PLD_LD_EN_BIT 3
`define PLD_LD_WTYPE_BIT 6
`define PLD_LD_WDUR_LSB 7
`define PLD_LD_RATE_LSB 10
`define PLD_LD_TEST_BIT 12
`define PLD_LD_RELOCK_BIT 13
`define PLD_LD_RST 14'h000D

// ----------------------------------------------------------------
// analog_block_enables fields
// ----------------------------------------------------------------
`define PLD_AE_PAD_BIT 5
`define PLD_AE_RF_LSB 12
`define PLD_AE_DRS_LSB 15
`define PLD_AE_DIV2_BIT 19
`define PLD_AE_HIREF_BIT 21
`define PLD_AE_RST 24'hC1BEFF

// ----------------------------------------------------------------
// pin control fields and status bits
// ----------------------------------------------------------------
`define PLD_PIN_SEL_BIT 0
`define PLD_PIN_GATE_BIT 1
`define PLD_PIN_GPO_BIT 2
`define PLD_PIN_SRC_BIT 3
`define PLD_ST_LOCK 0
`define PLD_ST_LOST 1
`define PLD_ST_RELOCK 2

// ----------------------------------------------------------------
// window timer: longest window is 128 half ticks of 8 clocks
// ----------------------------------------------------------------
`define PLD_WIN_W 11

`endif

// file: rtl/pld_pkg.sv
/*
 * Types shared by the lock-detect block: the analog enable bundle and
 * the lock status bundle.
 * Assumes the map header supplies all numeric constants.
 */
package pld_pkg;

    // analog section gates and bias codes, as driven to the analog core
    typedef struct packed {
        logic [11:0] gates;
        logic [2:0] rfBias;
        logic rfOn;
        logic [2:0] resyncBias;
        logic resyncOn;
        logic div2En;
        logic hiRef;
    } pld_ana_t;

    // lock detector state seen by the outside
    typedef struct packed {
        logic locked;
        logic relockReq;
    } pld_lock_t;

    typedef enum logic [1:0] {
        PLD_IDLE = 2'b00,
        PLD_HUNT = 2'b01,
        PLD_LOCK = 2'b10
    } pld_state_t;

endpackage

// file: rtl/pld_win_timer.sv
/*
 * Digital lock-window timer: opens a window of programmable width on
 * start and closes it again, or keeps re-opening it in test mode.
 * Assumes start is a one-cycle pulse on sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pld_map.svh"

module pld_win_timer
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic contMode,
    input wire logic [2:0] widthCode,
    input wire logic [1:0] rateCode,
    output logic winOpen,
    output logic winExpire
);

    logic [`PLD_WIN_W-1:0] winLen;
    logic [`PLD_WIN_W-1:0] remQ;

    // half ticks double per width code; each half tick lasts 2^rate clocks
    always_comb
    begin
        winLen = `PLD_WIN_W'(11'h001 << widthCode) << rateCode;
    end

    // countdown: one-shot unless test mode keeps reloading
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            remQ <= 11'h000;
            winOpen <= 1'b0;
            winExpire <= 1'b0;
        end
        else
        begin
            winExpire <= 1'b0;
            if (start)
            begin
                remQ <= winLen;
                winOpen <= 1'b1;
            end
            else if (winOpen && remQ == 11'h001)
            begin
                winExpire <= 1'b1;
                remQ <= winLen;
                winOpen <= contMode;
            end
            else if (winOpen)
            begin
                remQ <= remQ - 11'h001;
            end
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_win_length: assert property ($fell(winOpen) |-> $past(remQ) == 11'h001)
        else $error("window closed before its count ran out");
    // judge the mode as it stood at the expiry edge; a config write may land on that edge
    a_oneshot_close: assert property (winExpire && !$past(contMode) |-> !winOpen)
        else $error("one-shot window stayed open");
    a_test_reopen: assert property (winExpire && $past(contMode) |-> winOpen)
        else $error("test mode window did not reopen");

endmodule
`default_nettype wire

// file: rtl/pld_lock_detect.sv
/*
 * Lock detector and analog enable registers of the synthesizer, with a
 * classic Wishbone slave, sticky event status and an interrupt line.
 * Assumes reference and divided-VCO edges and the analog window verdict
 * arrive as asynchronous pins; readback data comes from sys_clk logic.
 */
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "pld_map.svh"

// Contract
// - lock after 5..65535 consecutive in-window comparisons, chosen by 3-bit code
// - lock detector runs only while its enable bit is set; resets set
// - window-type 1 uses digital timer, 0 uses analog one-shot window
// - digital window width: half cycle for code 0, doubling up to 64
// - 2-bit rate field: 00 fastest timer, 11 slowest
// - test bit keeps timer running continuously; otherwise one-shot windows
// - auto-relock makes one reacquire attempt after lock fails, never retries
// - pad enable off disables pin; select picks lock/GENERAL_PURPOSE_OUTPUT or gated readback
// - RF buffer and resync fields are biases: 0 off, 1 low, 7 high
// - divide-by-two stage enabled only while its bit is set
module pld_lock_detect
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic refEdge,
    input wire logic vcoEdge,
    input wire logic analogInWin,
    input wire logic readbackData,
    output logic lockPinOut,
    output logic lockPinOe,
    output pld_pkg::pld_ana_t anaEn,
    output pld_pkg::pld_lock_t lockState,
    output logic irq
);

    // ----------------------------------------------------------------
    // registers and internal signals
    // ----------------------------------------------------------------
    logic [13:0] ldCfgQ;
    logic [23:0] anaQ;
    logic [3:0] pinQ;
    logic [2:0] statQ, ienQ, syncRefQ, syncVcoQ, evVec;
    logic [1:0] syncWinQ;
    logic [15:0] cntQ, targetCnt;
    logic [7:0] regIdx;
    logic [31:0] wMask;
    pld_pkg::pld_state_t stateQ;
    logic triedQ, refEv, vcoEv, ldOn, digital, inWin, hitEv, missEv;
    logic lockEv, lostEv, relockEv, winStart, winOpen, winExpire, busReq, busWr;

    // ----------------------------------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------------------------------
    // third stage only feeds the edge compare, never the first stage
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            syncRefQ <= 3'h0;
            syncVcoQ <= 3'h0;
            syncWinQ <= 2'h0;
        end
        else
        begin
            syncRefQ <= {syncRefQ[1:0], refEdge};
            syncVcoQ <= {syncVcoQ[1:0], vcoEdge};
            syncWinQ <= {syncWinQ[0], analogInWin};
        end
    end

    assign refEv = syncRefQ[1] & ~syncRefQ[2];
    assign vcoEv = syncVcoQ[1] & ~syncVcoQ[2];

    // ----------------------------------------------------------------
    // window selection and comparison verdict
    // ----------------------------------------------------------------
    assign ldOn = ldCfgQ[`PLD_LD_EN_BIT];
    assign digital = ldCfgQ[`PLD_LD_WTYPE_BIT];
    assign winStart = ldOn & digital & refEv;
    // the analog one-shot judges the edge itself; we only sample its verdict
    assign inWin = digital ? winOpen : syncWinQ[1];
    assign hitEv = ldOn & vcoEv & inWin;
    assign missEv = ldOn & vcoEv & ~inWin;

    pld_win_timer u_timer
    (
        .sys_clk(sys_clk), .rstn(rstn), .start(winStart), .contMode(ldCfgQ[`PLD_LD_TEST_BIT]),
        .widthCode(ldCfgQ[`PLD_LD_WDUR_LSB +: 3]), .rateCode(ldCfgQ[`PLD_LD_RATE_LSB +: 2]),
        .winOpen(winOpen), .winExpire(winExpire)
    );

    // consecutive count table
    always_comb
    begin
        case (ldCfgQ[`PLD_LD_CNT_LSB +: 3])
            3'h0: targetCnt = 16'h0005;
            3'h1: targetCnt = 16'h0020;
            3'h2: targetCnt = 16'h0060;
            3'h3: targetCnt = 16'h0100;
            3'h4: targetCnt = 16'h0200;
            3'h5: targetCnt = 16'h0800;
            3'h6: targetCnt = 16'h2000;
            default: targetCnt = 16'hFFFF;
        endcase
    end

    assign lockEv = hitEv & (stateQ == pld_pkg::PLD_HUNT) & (cntQ + 16'h0001 == targetCnt);
    assign lostEv = missEv & (stateQ == pld_pkg::PLD_LOCK);
    assign relockEv = lostEv & ldCfgQ[`PLD_LD_RELOCK_BIT] & ~triedQ;

    // ----------------------------------------------------------------
    // lock state machine and counter
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stateQ <= pld_pkg::PLD_IDLE;
            cntQ <= 16'h0000;
        end
        else if (!ldOn)
        begin
            stateQ <= pld_pkg::PLD_IDLE;
            cntQ <= 16'h0000;
        end
        else
        begin
            case (stateQ)
                pld_pkg::PLD_IDLE:
                begin
                    stateQ <= pld_pkg::PLD_HUNT;
                    cntQ <= 16'h0000;
                end
                pld_pkg::PLD_HUNT:
                begin
                    if (missEv)
                        cntQ <= 16'h0000;
                    else if (lockEv)
                        stateQ <= pld_pkg::PLD_LOCK;
                    else if (hitEv)
                        cntQ <= cntQ + 16'h0001;
                end
                pld_pkg::PLD_LOCK:
                begin
                    if (missEv)
                    begin
                        stateQ <= pld_pkg::PLD_HUNT;
                        cntQ <= 16'h0000;
                    end
                end
                default: stateQ <= pld_pkg::PLD_IDLE;
            endcase
        end
    end

    // one relock try per loss; the try is re-armed only by a fresh lock
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            triedQ <= 1'b0;
            lockState <= '0;
        end
        else
        begin
            if (lockEv)
                triedQ <= 1'b0;
            else if (relockEv)
                triedQ <= 1'b1;
            lockState.locked <= ldOn & (lockEv | (stateQ == pld_pkg::PLD_LOCK & ~missEv));
            lockState.relockReq <= relockEv;
        end
    end

    // ----------------------------------------------------------------
    // Wishbone slave: one wait state, ack for one cycle
    // ----------------------------------------------------------------
    assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign busWr = busReq & wb_we_i;
    assign regIdx = wb_adr_i[`PLD_ADDR_W+1:2];
    assign wMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // writes land on the ack edge; unmapped indices read zero
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= busReq;
            wb_dat_o <= 32'h0000_0000;
            if (busReq && !wb_we_i)
            begin
                if (regIdx == `PLD_IDX_LDCFG)
                    wb_dat_o <= {18'h0, ldCfgQ & 14'h3FCF};
                else if (regIdx == `PLD_IDX_ANAEN)
                    wb_dat_o <= {8'h0, anaQ};
                else if (regIdx == `PLD_IDX_STAT)
                    wb_dat_o <= {29'h0, statQ};
                else if (regIdx == `PLD_IDX_IEN)
                    wb_dat_o <= {29'h0, ienQ};
                else if (regIdx == `PLD_IDX_PIN)
                    wb_dat_o <= {28'h0, pinQ};
            end
        end
    end

    // configuration registers, byte-lane masked
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ldCfgQ <= `PLD_LD_RST;
            anaQ <= `PLD_AE_RST;
            ienQ <= 3'h0;
            pinQ <= 4'h0;
        end
        else if (busWr)
        begin
            if (regIdx == `PLD_IDX_LDCFG)
                ldCfgQ <= (ldCfgQ & ~wMask[13:0]) | (wb_dat_i[13:0] & wMask[13:0]);
            else if (regIdx == `PLD_IDX_ANAEN)
                anaQ <= (anaQ & ~wMask[23:0]) | (wb_dat_i[23:0] & wMask[23:0]);
            else if (regIdx == `PLD_IDX_IEN && wb_sel_i[0])
                ienQ <= wb_dat_i[2:0];
            else if (regIdx == `PLD_IDX_PIN && wb_sel_i[0])
                pinQ <= wb_dat_i[3:0];
        end
    end

    // ----------------------------------------------------------------
    // sticky events and interrupt
    // ----------------------------------------------------------------
    assign evVec = {relockEv, lostEv, lockEv};

    // a new event outranks a clear in the same cycle
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            statQ <= 3'h0;
            irq <= 1'b0;
        end
        else
        begin
            if (busWr && regIdx == `PLD_IDX_CLR && wb_sel_i[0])
                statQ <= (statQ & ~wb_dat_i[2:0]) | evVec;
            else
                statQ <= statQ | evVec;
            irq <= |(statQ & ienQ);
        end
    end

    // ----------------------------------------------------------------
    // analog enables and shared output pin
    // ----------------------------------------------------------------
    // bias code 0 turns the section off; any other code is a bias level
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            anaEn <= '0;
        else
        begin
            anaEn.gates <= anaQ[11:0];
            anaEn.rfBias <= anaQ[`PLD_AE_RF_LSB +: 3];
            anaEn.rfOn <= |anaQ[`PLD_AE_RF_LSB +: 3];
            anaEn.resyncBias <= anaQ[`PLD_AE_DRS_LSB +: 3];
            anaEn.resyncOn <= |anaQ[`PLD_AE_DRS_LSB +: 3];
            anaEn.div2En <= anaQ[`PLD_AE_DIV2_BIT];
            anaEn.hiRef <= anaQ[`PLD_AE_HIREF_BIT];
        end
    end

    // pin drives lock or GENERAL_PURPOSE_OUTPUT when selected, else readback unless gated off
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            lockPinOut <= 1'b0;
            lockPinOe <= 1'b0;
        end
        else
        begin
            lockPinOe <= anaQ[`PLD_AE_PAD_BIT] &
                (pinQ[`PLD_PIN_SEL_BIT] | ~pinQ[`PLD_PIN_GATE_BIT]);
            if (pinQ[`PLD_PIN_SEL_BIT])
                lockPinOut <= pinQ[`PLD_PIN_SRC_BIT] ? pinQ[`PLD_PIN_GPO_BIT] : lockState.locked;
            else
                lockPinOut <= readbackData;
        end
    end

    // ----------------------------------------------------------------
    // assertions and covers
    // ----------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    a_lock_count: assert property ($rose(stateQ == pld_pkg::PLD_LOCK) |->
        $past(cntQ) + 16'h0001 == $past(targetCnt))
        else $error("lock declared before the count was reached");
    a_disabled_idle: assert property (!ldOn |=> stateQ == pld_pkg::PLD_IDLE ##1 !lockState.locked)
        else $error("lock detector active while disabled");
    a_digital_start: assert property (winStart |=> winOpen)
        else $error("digital window did not open on reference edge");
    a_relock_cause: assert property (lockState.relockReq |-> $past(lostEv) && $past(ldCfgQ[13]))
        else $error("relock request without a lost lock");
    a_no_retry: assert property (triedQ && missEv |=> !lockState.relockReq)
        else $error("second relock attempt made");
    a_pad_off: assert property (!anaQ[`PLD_AE_PAD_BIT] |=> !lockPinOe)
        else $error("pin driven with pad disabled");
    a_miss_clears: assert property (missEv |=> cntQ == 16'h0000 ##1 !lockState.locked)
        else $error("miss did not restart the count");
    a_irq_level: assert property (|(statQ & ienQ) |=> irq)
        else $error("interrupt not raised for enabled event");

    c_lock: cover property (lockEv);
    c_relock: cover property (relockEv);
    c_digital_hit: cover property (digital && hitEv);
endmodule
`default_nettype wire

// file: bench/pld_pin_model.sv
/*
 * Pin-side model: reference edge, divided-VCO edge and analog verdict.
 * Assumes sys_clk is the bench clock; pins are plain push-pull inputs.
 */
`timescale 1ns/1ps
`default_nettype none
module pld_pin_model
(
    input wire logic sys_clk,
    output logic refEdge,
    output logic vcoEdge,
    output logic analogInWin
);
    // --------------------------------
    // edge generation
    // --------------------------------
    // edge pins idle low between comparisons; the verdict pin starts high
    initial
    begin
        refEdge = 1'b0;
        vcoEdge = 1'b0;
        analogInWin = 1'b1;
    end
    // one comparison: vco edge lag cycles after the reference edge
    task automatic compare(input int lag, input logic inWin);
        @(posedge sys_clk);
        refEdge <= 1'b1;
        repeat (lag) @(posedge sys_clk);
        vcoEdge <= 1'b1;
        analogInWin <= inWin;
        repeat (4) @(posedge sys_clk);
        refEdge <= 1'b0;
        vcoEdge <= 1'b0;
        analogInWin <= ~inWin; // verdict no longer held: never a stale value
        repeat (24) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// file: bench/pld_lock_detect_tb.sv
/*
 * Self-checking bench: Wishbone register tasks and lock scenarios.
 * Assumes the pin model drives the reference and VCO pins.
 */
`timescale 1ns/1ps
`default_nettype none
module pld_lock_detect_tb;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [31:0] adr = 32'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic rbData = 1'b0;
    logic [31:0] datO;
    logic [31:0] rdat;
    logic ack, pinOut, pinOe, irq, refEdge, vcoEdge, inWin;
    pld_pkg::pld_ana_t ana;
    pld_pkg::pld_lock_t lk;
    int n_fail = 0;
    int checked = 0;
    int nRelock = 0;
    int n0;
    int cnts [4] = '{5, 32, 96, 256};
    logic [3:0] wdT [4] = '{4'h0, 4'h4, 4'hC, 4'h3};
    logic [3:0] pvT [7] = '{4'h5, 4'hD, 4'h9, 4'h1, 4'h0, 4'h0, 4'h2};
    logic rbT [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    logic [1:0] exT [7] = '{2'b00, 2'b11, 2'b10, 2'b11, 2'b11, 2'b10, 2'b00};

    // --------------------------------
    // clock, pulse counter, instances
    // --------------------------------
    always #10 sys_clk = ~sys_clk;
    // relock request lasts one cycle, so it is counted, not polled
    always @(posedge sys_clk)
    begin
        if (lk.relockReq === 1'b1)
            nRelock <= nRelock + 1;
    end
    pld_lock_detect i_pld_lock_detect
    (
        .sys_clk(sys_clk), .rstn(rstn), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
        .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(datO), .wb_ack_o(ack),
        .refEdge(refEdge), .vcoEdge(vcoEdge), .analogInWin(inWin), .readbackData(rbData),
        .lockPinOut(pinOut), .lockPinOe(pinOe), .anaEn(ana), .lockState(lk), .irq(irq)
    );
    pld_pin_model i_pld_pin_model
    (
        .sys_clk(sys_clk), .refEdge(refEdge), .vcoEdge(vcoEdge), .analogInWin(inWin)
    );

    // --------------------------------
    // tasks
    // --------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // classic cycle; the request stands until ack is sampled high
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int i;
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        for (i = 0; i < 16; i++)
        begin
            @(posedge sys_clk);
            if (ack === 1'b1)
                break;
        end
        rdat = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (i == 16)
        begin
            n_fail++;
            test_done();
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
        repeat (3) @(posedge sys_clk); // outputs follow the register late
    endtask
    task automatic rd(input logic [31:0] a);
        bus(1'b0, a, 32'h0, 4'hF);
    endtask
    task automatic cmp(input int n, input int lag, input logic v);
        repeat (n) i_pld_pin_model.compare(lag, v);
    endtask
    task automatic lockIs(input logic e);
        chk("locked", 32'(lk.locked), 32'(e));
    endtask
    // lock config word; bit 3 enable always set here
    function automatic logic [31:0] ldc(input logic [2:0] c, input logic dg,
                                        input logic [2:0] du, input logic [1:0] ra,
                                        input logic ts, input logic rl);
        return {18'h0, rl, ts, ra, du, dg, 2'b00, 1'b1, c};
    endfunction

    // --------------------------------
    // scenarios
    // --------------------------------
    initial
    begin
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(32'h1C);
        chk("ldcfg reset", rdat, 32'h0000000D);
        rd(32'h20);
        chk("anaEn reset", rdat, 32'h00C1BEFF);
        chk("anaEn out", 32'(ana), {10'h0, 12'hEFF, 3'h3, 1'b1, 3'h3, 1'b1, 2'b00});
        wr(32'h1C, 32'hFFFFFFFF);
        rd(32'h1C);
        chk("ldcfg rw", rdat, 32'h00003FCF);
        wr(32'h20, 32'hFFFFFFFF);
        chk("anaEn max", 32'(ana), {10'h0, 12'hFFF, 3'h7, 1'b1, 3'h7, 1'b1, 2'b11});
        bus(1'b1, 32'h20, 32'h0, 4'h1);
        rd(32'h20);
        chk("anaEn lane", rdat, 32'h00FFFF00);
        wr(32'h20, 32'h00C00EFF);
        chk("bias off", 32'(ana), {10'h0, 12'hEFF, 3'h0, 1'b0, 3'h0, 1'b0, 2'b00});
        wr(32'h3C, 32'h1234);
        rd(32'h3C);
        chk("unmapped", rdat, 32'h0);
        wr(32'h40, 32'hFF);
        rd(32'h40);
        chk("status ro", rdat, 32'h0);
        wr(32'h20, 32'h00C1BEFF);
        $display("test registers done");
        wr(32'h48, 32'h7);
        for (int k = 0; k < 4; k++)
        begin
            wr(32'h1C, ldc(3'(k), 1'b1, 3'h2, 2'h1, 1'b0, 1'b0));
            cmp(1, 40, 1'b0);
            cmp(cnts[k] - 1, 4, 1'b1);
            lockIs(1'b0);
            cmp(1, 4, 1'b1);
            lockIs(1'b1);
        end
        wr(32'h44, 32'h7);
        cmp(1, 40, 1'b0);
        lockIs(1'b0);
        rd(32'h40);
        chk("status lost", rdat, 32'h2);
        chk("irq on", 32'(irq), 32'h1);
        wr(32'h48, 32'h0);
        chk("irq masked", 32'(irq), 32'h0);
        wr(32'h48, 32'h7);
        chk("irq again", 32'(irq), 32'h1);
        wr(32'h44, 32'h2);
        chk("irq cleared", 32'(irq), 32'h0);
        chk("no relock", nRelock, 32'h0);
        $display("test counts done");
        wr(32'h1C, ldc(3'h0, 1'b1, 3'h2, 2'h1, 1'b0, 1'b0) & 32'hFFF7);
        cmp(6, 4, 1'b1);
        lockIs(1'b0);
        wr(32'h1C, ldc(3'h0, 1'b1, 3'h2, 2'h1, 1'b0, 1'b0));
        cmp(5, 4, 1'b1);
        lockIs(1'b1);
        wr(32'h1C, ldc(3'h0, 1'b1, 3'h2, 2'h1, 1'b0, 1'b0) & 32'hFFF7);
        lockIs(1'b0);
        wr(32'h1C, ldc(3'h0, 1'b0, 3'h3, 2'h1, 1'b0, 1'b0));
        cmp(1, 4, 1'b0);
        cmp(5, 40, 1'b1);
        lockIs(1'b1);
        cmp(1, 4, 1'b0);
        lockIs(1'b0);
        $display("test enable and analog done");
        // width and rate pairs: only wide enough windows catch a lag of 4
        for (int k = 0; k < 4; k++)
        begin
            wr(32'h1C, ldc(3'h0, 1'b1, 3'(wdT[k][3:2]), wdT[k][1:0], 1'b0, 1'b0));
            cmp(1, 40, 1'b0);
            cmp(5, 4, 1'b1);
            lockIs(k > 1);
        end
        for (int k = 0; k < 2; k++)
        begin
            wr(32'h1C, ldc(3'h0, 1'b1, 3'h2, 2'h1, 1'(k), 1'b0));
            cmp(5, 37, 1'b1);
            lockIs(1'(k));
        end
        $display("test window done");
        wr(32'h1C, ldc(3'h0, 1'b1, 3'h2, 2'h1, 1'b0, 1'b1));
        cmp(1, 40, 1'b0);
        n0 = nRelock;
        wr(32'h44, 32'h7);
        cmp(5, 4, 1'b1);
        cmp(1, 40, 1'b0);
        chk("relock once", nRelock, n0 + 1);
        rd(32'h40);
        chk("status relock", rdat, 32'h7);
        cmp(1, 40, 1'b0);
        chk("no retry", nRelock, n0 + 1);
        cmp(5, 4, 1'b1);
        cmp(1, 40, 1'b0);
        chk("rearmed", nRelock, n0 + 2);
        $display("test relock done");
        cmp(5, 4, 1'b1);
        for (int k = 0; k < 7; k++)
        begin
            wr(32'h20, (k == 0) ? 32'h00C1BEDF : 32'h00C1BEFF);
            wr(32'h4C, 32'(pvT[k]));
            rbData <= rbT[k];
            repeat (4) @(posedge sys_clk);
            chk("pin", {30'h0, pinOe, pinOe & pinOut}, 32'(exT[k]));
        end
        $display("test pin done");
        test_done();
    end
endmodule
`default_nettype wire
